/* upcr_pkg.sv */
`default_nettype none

package upcr_pkg;

	// Register map and data width of the management window.
	localparam int REG_W = 8;
	localparam int ADDR_W = 8;
	localparam logic [7:0] OFS_TEST_A = 8'hBF;
	localparam logic [7:0] OFS_CTRL1 = 8'hCF;
	localparam logic [7:0] OFS_CTRL2 = 8'hDF;
	localparam logic [7:0] OFS_TEST_B = 8'hEF;
	localparam logic [7:0] OFS_P4CTL = 8'hFF;

	// Fixed contents of the two test registers.
	localparam logic [7:0] TEST_A_VAL = 8'h80;
	localparam logic [7:0] TEST_B_VAL = 8'h32;

	// First control register of the third port: field positions and values.
	localparam int C1_HALF_BIT = 7;
	localparam int C1_FLOW_BIT = 6;
	localparam int C1_SPEED_BIT = 5;
	localparam logic C1_HALF_RST = 1'b0;
	localparam logic C1_FLOW_RST = 1'b0;
	localparam logic C1_SPEED_RST = 1'b0;
	localparam logic [4:0] C1_RSVD_VAL = 5'h15;

	// Second control register of the third port.
	localparam int C2_MODE_BIT = 6;
	localparam logic C2_MODE_RST = 1'b0;
	localparam logic C2_TOP_VAL = 1'b0;
	localparam logic [5:0] C2_RSVD_VAL = 6'h2C;

	// Testing and fourth port control register.
	localparam int P4_INV_BIT = 6;
	localparam logic P4_INV_RST = 1'b0;
	localparam logic P4_TOP_VAL = 1'b0;
	localparam logic [5:0] P4_RSVD_VAL = 6'h00;

	// Serial management frame layout.
	localparam int PRE_ONES = 32;
	localparam int HDR_BITS = 12;
	localparam int TA_BITS = 2;
	localparam int DATA_BITS = 16;
	localparam logic [1:0] OP_RD = 2'b10;
	localparam logic [1:0] OP_WR = 2'b01;

	typedef enum logic [2:0] {S_PRE, S_START, S_HDR, S_TA, S_DATA} upcr_state_t;

	// Read view of one register; reserved fields always show their fixed values.
	function automatic logic [7:0] upcr_read(
		input logic [7:0] addr,
		input logic half,
		input logic flow,
		input logic speed,
		input logic mac,
		input logic inv
	);
		logic [7:0] val;
		val = 8'h00;
		unique case (addr)
			OFS_TEST_A: val = TEST_A_VAL;
			OFS_CTRL1: val = {half, flow, speed, C1_RSVD_VAL};
			OFS_CTRL2: val = {C2_TOP_VAL, mac, C2_RSVD_VAL};
			OFS_TEST_B: val = TEST_B_VAL;
			OFS_P4CTL: val = {P4_TOP_VAL, inv, P4_RSVD_VAL};
			default: val = 8'h00;
		endcase
		return val;
	endfunction

endpackage

`default_nettype wire

/* upcr_sync.sv */
`timescale 1ns/1ps
`default_nettype none

module upcr_sync #(
	parameter int WIDTH = 3,
	parameter int STAGES = 2
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);

	generate
		if (STAGES < 2)
		begin : g_bad
			$error("upcr_sync needs at least two stages");
		end
	endgenerate

	logic [WIDTH-1:0] stage [STAGES];

	// Plain shift chain; only the last stage is visible to other logic.
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			for (int i = 0; i < STAGES; i++)
				stage[i] <= '0;
		end
		else
		begin
			stage[0] <= async_in;
			for (int i = 1; i < STAGES; i++)
				stage[i] <= stage[i-1];
		end
	end

	assign sync_out = stage[STAGES-1];

endmodule // upcr_sync

`default_nettype wire

/* upcr_regs.sv */
// Contract
// - Test register 0xBF reads 0x80, read-only.
// - Control one bit 7 selects half duplex.
// - Control one bit 6 enables flow control.
// - Control one bit 5 selects 10 Mb/s.
// - Control two mode bit selects MAC personality.
// - Test register 0xEF reads 0x32, read-only.
// - Invert bit flips fourth port clock phase.
`timescale 1ns/1ps
`default_nettype none

module upcr_regs
	import upcr_pkg::*;
#(
	parameter int PREAMBLE_ONES = upcr_pkg::PRE_ONES
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic mdc,
	input wire logic mdio_in,
	output logic mdio_out,
	output logic mdio_oe,
	input wire logic fourth_port_tx_clock_in,
	output logic fourth_port_tx_clock_phased,
	output logic third_port_half_duplex,
	output logic third_port_flow_ctrl_en,
	output logic third_port_speed_10,
	output logic third_port_mac_mode,
	output logic fourth_port_tx_clk_invert
);

	import upcr_pkg::*;

	generate
		if (PREAMBLE_ONES < 1 || PREAMBLE_ONES > 63)
		begin : g_bad_pre
			$error("PREAMBLE_ONES must lie in 1..63");
		end
	endgenerate

	localparam logic [5:0] PRE_TGT = 6'(PREAMBLE_ONES);
	localparam logic [4:0] HDR_LAST = 5'(HDR_BITS - 1);
	localparam logic [4:0] TA_LAST = 5'(TA_BITS - 1);
	localparam logic [4:0] DATA_LAST = 5'(DATA_BITS - 1);

	// Reset is applied at once but released through two flops.
	logic rst_meta;
	logic rst_n;
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end
		else
		begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	// Management clock, data and the fourth port clock come from outside.
	logic [2:0] pins_s;
	upcr_sync #(.WIDTH(3), .STAGES(2)) u_sync (
		.clk(core_clk),
		.rst_n(rst_n),
		.async_in({fourth_port_tx_clock_in, mdio_in, mdc}),
		.sync_out(pins_s)
	);

	wire logic mdc_s = pins_s[0];
	wire logic mdio_s = pins_s[1];
	wire logic txc_s = pins_s[2];

	// Frame state and configuration state.
	upcr_state_t state;
	upcr_state_t next_state;
	logic mdc_d;
	logic [4:0] bit_cnt;
	logic [4:0] next_bit_cnt;
	logic [5:0] ones_cnt;
	logic [5:0] next_ones_cnt;
	logic [15:0] shreg;
	logic [15:0] rd_word;
	logic [15:0] next_rd_word;
	logic is_read;
	logic next_is_read;
	logic [7:0] addr;
	logic [7:0] next_addr;
	logic next_mdio_out;
	logic next_mdio_oe;

	// Edges of the sampled management clock; the block samples and drives data on the rise.
	wire logic mdc_rise = mdc_s & ~mdc_d;
	wire logic [11:0] hdr_word = {shreg[10:0], mdio_s};
	wire logic [1:0] hdr_op = hdr_word[11:10];
	wire logic [7:0] hdr_addr = {hdr_word[7:5], hdr_word[4:0]};
	wire logic [7:0] wr_byte = {shreg[6:0], mdio_s};
	wire logic [7:0] hdr_rdata = upcr_read(hdr_addr, third_port_half_duplex,
		third_port_flow_ctrl_en, third_port_speed_10, third_port_mac_mode,
		fourth_port_tx_clk_invert);
	wire logic frame_end = mdc_rise && state == S_DATA && bit_cnt == DATA_LAST;
	wire logic wr_fire = frame_end && !is_read;

	// Write decode: only the documented control bits accept host data.
	wire logic wr_ctrl1 = wr_fire && addr == OFS_CTRL1;
	wire logic wr_ctrl2 = wr_fire && addr == OFS_CTRL2;
	wire logic wr_p4ctl = wr_fire && addr == OFS_P4CTL;

	// Frame sequencer: preamble, start, header, turnaround, data.
	always_comb
	begin
		next_state = state;
		next_bit_cnt = bit_cnt;
		next_ones_cnt = ones_cnt;
		next_rd_word = rd_word;
		next_is_read = is_read;
		next_addr = addr;
		next_mdio_out = mdio_out;
		next_mdio_oe = mdio_oe;
		if (mdc_rise)
		begin
			unique case (state)
				S_PRE:
				begin
					if (mdio_s)
					begin
						if (ones_cnt < PRE_TGT)
							next_ones_cnt = ones_cnt + 6'h01;
					end
					else if (ones_cnt >= PRE_TGT)
						next_state = S_START;
					else
						next_ones_cnt = 6'h00;
				end
				S_START:
				begin
					next_bit_cnt = 5'h00;
					next_ones_cnt = 6'h00;
					next_state = mdio_s ? S_HDR : S_PRE;
				end
				S_HDR:
				begin
					next_bit_cnt = bit_cnt + 5'h01;
					if (bit_cnt == HDR_LAST)
					begin
						next_bit_cnt = 5'h00;
						next_addr = hdr_addr;
						next_is_read = (hdr_op == OP_RD);
						next_rd_word = {8'h00, hdr_rdata};
						// An unknown opcode abandons the frame quietly.
						next_state = (hdr_op == OP_RD || hdr_op == OP_WR) ? S_TA : S_PRE;
					end
				end
				S_TA:
				begin
					next_bit_cnt = bit_cnt + 5'h01;
					if (is_read)
					begin
						next_mdio_oe = 1'b1;
						next_mdio_out = 1'b0;
					end
					if (bit_cnt == TA_LAST)
					begin
						next_bit_cnt = 5'h00;
						next_state = S_DATA;
						if (is_read)
						begin
							next_mdio_out = rd_word[15];
							next_rd_word = {rd_word[14:0], 1'b0};
						end
					end
				end
				S_DATA:
				begin
					next_bit_cnt = bit_cnt + 5'h01;
					if (is_read)
					begin
						next_mdio_out = rd_word[15];
						next_rd_word = {rd_word[14:0], 1'b0};
					end
					if (bit_cnt == DATA_LAST)
					begin
						next_bit_cnt = 5'h00;
						next_state = S_PRE;
						next_mdio_oe = 1'b0;
						next_mdio_out = 1'b0;
					end
				end
			endcase
		end
	end

	// Sequencer registers.
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state <= S_PRE;
			mdc_d <= 1'b0;
			bit_cnt <= 5'h00;
			ones_cnt <= 6'h00;
			rd_word <= 16'h0000;
			is_read <= 1'b0;
			addr <= 8'h00;
			mdio_out <= 1'b0;
			mdio_oe <= 1'b0;
		end
		else
		begin
			state <= next_state;
			mdc_d <= mdc_s;
			bit_cnt <= next_bit_cnt;
			ones_cnt <= next_ones_cnt;
			rd_word <= next_rd_word;
			is_read <= next_is_read;
			addr <= next_addr;
			mdio_out <= next_mdio_out;
			mdio_oe <= next_mdio_oe;
		end
	end

	// Incoming bits are shifted on every sampled rise; the last byte is the write data.
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			shreg <= 16'h0000;
		else if (mdc_rise)
			shreg <= {shreg[14:0], mdio_s};
	end

	// Configuration bits; reserved fields have no storage, so writes cannot reach them.
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			third_port_half_duplex <= C1_HALF_RST;
			third_port_flow_ctrl_en <= C1_FLOW_RST;
			third_port_speed_10 <= C1_SPEED_RST;
			third_port_mac_mode <= C2_MODE_RST;
			fourth_port_tx_clk_invert <= P4_INV_RST;
		end
		else
		begin
			if (wr_ctrl1)
			begin
				third_port_half_duplex <= wr_byte[C1_HALF_BIT];
				third_port_flow_ctrl_en <= wr_byte[C1_FLOW_BIT];
				third_port_speed_10 <= wr_byte[C1_SPEED_BIT];
			end
			if (wr_ctrl2)
				third_port_mac_mode <= wr_byte[C2_MODE_BIT];
			if (wr_p4ctl)
				fourth_port_tx_clk_invert <= wr_byte[P4_INV_BIT];
		end
	end

	// Phase-adjusted copy of the fourth port clock; it lags the pin by three
	// core cycles, which is acceptable only because the clock is far slower.
	always_ff @(posedge core_clk or negedge rst_n)
	begin
		if (!rst_n)
			fourth_port_tx_clock_phased <= 1'b0;
		else
			fourth_port_tx_clock_phased <= txc_s ^ fourth_port_tx_clk_invert;
	end

endmodule // upcr_regs

`default_nettype wire

/* upcr_regs_sva.sv */
`timescale 1ns/1ps
`default_nettype none

module upcr_regs_sva (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic mdio_out,
	input wire logic mdio_oe,
	input wire logic fourth_port_tx_clock_in,
	input wire logic fourth_port_tx_clock_phased,
	input wire logic third_port_half_duplex,
	input wire logic third_port_flow_ctrl_en,
	input wire logic third_port_speed_10,
	input wire logic third_port_mac_mode,
	input wire logic fourth_port_tx_clk_invert
);
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!resetn);
	logic [2:0] up;
	logic [7:0] oe_len;

	// The age count lets the clock path check skip the synchroniser fill after reset.
	always_ff @(posedge core_clk or negedge resetn)
	begin
		if (!resetn)
		begin
			up <= 3'h0;
			oe_len <= 8'h00;
		end
		else
		begin
			up <= (up == 3'h7) ? up : up + 3'h1;
			oe_len <= mdio_oe ? oe_len + 8'h01 : 8'h00;
		end
	end

	// Settings move only on writes, never while the block answers a read.
	a_half_on_write: assert property (!$stable(third_port_half_duplex) |-> !mdio_oe)
		else $error("half duplex moved during a read");
	a_flow_on_write: assert property (!$stable(third_port_flow_ctrl_en) |-> !mdio_oe)
		else $error("flow control moved during a read");
	a_speed_on_write: assert property (!$stable(third_port_speed_10) |-> !mdio_oe)
		else $error("speed moved during a read");
	a_mode_on_write: assert property (!$stable(third_port_mac_mode) |-> !mdio_oe)
		else $error("mode moved during a read");
	a_inv_on_write: assert property (!$stable(fourth_port_tx_clk_invert) |-> !mdio_oe)
		else $error("invert moved during a read");
	a_phase_path: assert property (up == 3'h7 && $stable(fourth_port_tx_clk_invert)
		|-> fourth_port_tx_clock_phased ==
		($past(fourth_port_tx_clock_in, 3) ^ $past(fourth_port_tx_clk_invert)))
		else $error("transmit clock phase wrong");
	a_read_ta_zero: assert property ($rose(mdio_oe) |-> !mdio_out)
		else $error("read turnaround not zero");
	a_read_oe_hold: assert property ($rose(mdio_oe) |-> mdio_oe [*8])
		else $error("read drive too short");
	a_read_oe_bound: assert property (oe_len <= 8'h8C)
		else $error("read drive too long");
endmodule // upcr_regs_sva

bind upcr_regs upcr_regs_sva i_upcr_regs_sva (.core_clk, .resetn, .mdio_out, .mdio_oe,
	.fourth_port_tx_clock_in, .fourth_port_tx_clock_phased, .third_port_half_duplex,
	.third_port_flow_ctrl_en, .third_port_speed_10, .third_port_mac_mode,
	.fourth_port_tx_clk_invert);

`default_nettype wire

/* upcr_host.sv */
`timescale 1ns/1ps
`default_nettype none

module upcr_host #(
	parameter int P = 2
) (
	input wire logic clk,
	input wire logic mdio_w,
	output logic mdc,
	output logic mdio_drv
);
	// Clock stands low and the line is released between frames.
	initial
	begin
		mdc = 1'b0;
		mdio_drv = 1'b1;
	end

	// One bit: returns the wire as it stood at the end of the previous high phase.
	task automatic bit_x(input logic b, output logic s);
		s = mdio_w;
		mdc = 1'b0;
		mdio_drv = b;
		repeat (4) @(posedge clk);
		#1 mdc = 1'b1;
		repeat (4) @(posedge clk);
		#1;
	endtask

	// Whole frame; reads release the line from turnaround on.
	task automatic xfer(input logic [1:0] op, input logic [7:0] a, input logic [15:0] wd,
		output logic [15:0] rd);
		logic [31:0] f;
		logic s;
		f = {2'b01, op, 2'b00, a, (op == 2'b10) ? 18'h3FFFF : {2'b10, wd}};
		repeat (P) bit_x(1'b1, s);
		for (int i = 31; i >= 0; i--)
		begin
			bit_x(f[i], s);
			if (i < 16)
				rd[i] = s;
		end
		mdc = 1'b0;
		mdio_drv = 1'b1;
		// One idle edge keeps this release apart from the next frame's first bit.
		@(posedge clk);
		#1;
	endtask
endmodule // upcr_host

`default_nettype wire

/* testbench.sv */
`timescale 1ns/1ps
`default_nettype none

module testbench;
	import upcr_pkg::*;
	logic core_clk = 1'b0;
	logic resetn = 1'b0;
	logic tx_clk = 1'b0;
	logic mdc, mdio_drv, mdio_out, mdio_oe, phased, half, flow, spd, mac, inv;
	logic [4:0] outs;
	wire logic mdio_w;
	int fail_count = 0;
	int tests_run = 0;

	// The host drives the line whenever the block is not driving it.
	assign mdio_w = mdio_oe ? mdio_out : mdio_drv;
	assign outs = {half, flow, spd, mac, inv};
	always #20 core_clk = ~core_clk;
	always
	begin
		repeat (3) @(posedge core_clk);
		#1 tx_clk = ~tx_clk;
	end

	upcr_regs #(.PREAMBLE_ONES(2)) i_upcr_regs (.core_clk(core_clk), .resetn(resetn),
		.mdc(mdc), .mdio_in(mdio_w), .mdio_out(mdio_out), .mdio_oe(mdio_oe),
		.fourth_port_tx_clock_in(tx_clk), .fourth_port_tx_clock_phased(phased),
		.third_port_half_duplex(half), .third_port_flow_ctrl_en(flow),
		.third_port_speed_10(spd), .third_port_mac_mode(mac),
		.fourth_port_tx_clk_invert(inv));
	upcr_host #(.P(2)) i_upcr_host (.clk(core_clk), .mdio_w(mdio_w), .mdc(mdc),
		.mdio_drv(mdio_drv));

	task automatic close_out;
		if (fail_count == 0 && tests_run > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	task automatic chk(input logic [15:0] g, input logic [15:0] e);
		tests_run++;
		if (g !== e)
		begin
			$display("BAD t=%0t got %h exp %h", $time, g, e);
			fail_count++;
		end
	endtask

	task automatic rd(input logic [7:0] a, input logic [7:0] e);
		logic [15:0] d;
		i_upcr_host.xfer(OP_RD, a, 16'h0000, d);
		chk(d, {8'h00, e});
	endtask

	// High byte carries junk that must be ignored; then the update latency passes.
	task automatic wr(input logic [7:0] a, input logic [7:0] v, input logic [1:0] op = OP_WR);
		logic [15:0] d;
		i_upcr_host.xfer(op, a, {8'hA5, v}, d);
		repeat (6) @(posedge core_clk);
		#1;
	endtask

	task automatic t_reset;
		chk({11'h000, outs}, 16'h0000);
		rd(8'hBF, 8'h80);
		rd(8'hCF, 8'h15);
		rd(8'hDF, 8'h2C);
		rd(8'hEF, 8'h32);
		rd(8'hFF, 8'h00);
	endtask

	task automatic t_ctrl1;
		for (int b = 5; b <= 7; b++)
		begin
			wr(8'hCF, 8'h01 << b);
			chk({11'h000, outs}, 16'h0001 << (b - 3));
			rd(8'hCF, (8'h01 << b) | 8'h15);
		end
		wr(8'hCF, 8'h00);
		rd(8'hCF, 8'h15);
	endtask

	// The phased clock is the pin seen three core edges late, flipped when v is set.
	task automatic phase_chk(input logic v);
		logic h;
		for (int k = 0; k < 6; k++)
		begin
			@(posedge core_clk);
			h = tx_clk;
			repeat (2) @(posedge core_clk);
			#1;
			chk({15'h0000, phased}, {15'h0000, h ^ v});
		end
	endtask

	task automatic t_mode_inv;
		wr(8'hDF, 8'hFF);
		chk({11'h000, outs}, 16'h0002);
		rd(8'hDF, 8'h6C);
		wr(8'hDF, 8'h00);
		wr(8'hFF, 8'hFF);
		chk({11'h000, outs}, 16'h0001);
		phase_chk(1'b1);
		rd(8'hFF, 8'h40);
		wr(8'hFF, 8'h00);
		chk({11'h000, outs}, 16'h0000);
		phase_chk(1'b0);
	endtask

	// A reset in mid-run must bring every setting back to its reset value.
	task automatic t_rearm;
		wr(8'hCF, 8'hE0);
		wr(8'hFF, 8'h40);
		chk({11'h000, outs}, 16'h001D);
		resetn = 1'b0;
		repeat (5) @(posedge core_clk);
		#1 resetn = 1'b1;
		repeat (5) @(posedge core_clk);
		#1;
		chk({11'h000, outs}, 16'h0000);
		rd(8'hCF, 8'h15);
		rd(8'hFF, 8'h00);
	endtask

	task automatic t_refused;
		wr(8'hBF, 8'h00);
		wr(8'hEF, 8'hFF);
		wr(8'h10, 8'hFF);
		wr(8'hCF, 8'hFF, 2'b11);
		rd(8'hBF, 8'h80);
		rd(8'hEF, 8'h32);
		rd(8'h10, 8'h00);
		rd(8'hCF, 8'h15);
	endtask

	initial
	begin
		repeat (100000) @(posedge core_clk);
		fail_count++;
		close_out();
	end

	initial
	begin
		repeat (5) @(posedge core_clk);
		#1 resetn = 1'b1;
		repeat (5) @(posedge core_clk);
		#1;
		t_reset();
		t_ctrl1();
		t_mode_inv();
		t_refused();
		t_rearm();
		close_out();
	end
endmodule // testbench

`default_nettype wire
